// >>> src/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] RELOAD_VALUE_ADDR  = 32'h4002_0400;
  localparam logic [31:0] CONTROL_ADDR       = 32'h4002_0404;
  localparam logic [31:0] RELOAD_STROBE_ADDR = 32'h4002_0408;
  localparam logic [31:0] CURRENT_COUNT_ADDR = 32'h4002_040C;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_ON_BIT        = 0;
  localparam int          CTRL_FLAG_BIT      = 1;
  localparam int          CTRL_HIB_BIT       = 2;
  localparam int          CTRL_WEEK_BIT      = 3;
  localparam int          CTRL_DEBUG_BIT     = 4;
  localparam logic [15:0] RELOAD_RESET       = 16'hFFFF;
  localparam logic [15:0] ZERO_COUNT         = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ           = 20_000_000;
  localparam int unsigned SLOW_HZ            = 32_768;
  localparam int unsigned CLOCK_PERIOD_PS    = 50_000;
  localparam int unsigned STEP_TIME_PS       = 1_007_000_000;
  // Longest wait for a crossing: rounds down
  localparam int unsigned SLOW_CYCLES        = CLOCK_HZ / SLOW_HZ;
  localparam int unsigned STEP_CYCLES        = STEP_TIME_PS / CLOCK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic        read;
    logic [31:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic hibernation_timer_running;
    logic week_timer_running;
    logic debug_port_running;
  } pause_in_t;

endpackage

// >>> src/watchdog_timer_with_stall.sv
`timescale 1ns/1ns
`default_nettype none

//Contract
// - While enabled, a missing reload before the interval ends gives an expiry event.
// - A reload request takes effect within one slow-clock period.
// - After a reload value write, enabling is held off up to one slow period.
// - Reads always accepted; clearing enable stops the watchdog at once.
// - Counter steps paced by a register-clock divider, requests by the slow rate; registers served on the register clock.
// - The expiry output forces a reset of the whole device.
// - The expiry event survives the forced reset as a reset-cause bit.
// - The expiry output is not wired to a controller interrupt.
// - Firmware writes reload value then sets enable; counting starts from that value.
// - Clearing enable resets, stops and gates the counter, expiry output low.
// - Underflow without reload gives an expiry event and sets the expiry flag.
// - One decrement every 1.007 ms; interval is reload value down to zero.
// - Enabled stall input stops counting; on release reload and resume.
// - Stall feature disabled out of reset.
// - Three stall inputs, each gated by its own enable bit.
// - At zero the counter reloads, restarts and pulses the expiry output.
// - Writing the 16-bit reload value reloads the counter; resets to all ones.
// - Counter clocking gated whenever the counter is inactive.
// - Four registers at consecutive words from the block base.
// - Kick writes ignored while enable is clear.
// - Kick reads zero; a kick while enabled reloads and keeps counting.
// - Expiry flag clears only on a written one; zero has no effect.
// - Control bit0 enable, bit1 expiry flag, bit4 debug stall enable.
module watchdog_timer_with_stall #(
  parameter int unsigned STEP_CYCLES_P = wdt_pkg::STEP_CYCLES
) (
  // Clock and power-on reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Controller register bus
  input  wire wdt_pkg::reg_req_t regReq,
  output logic [15:0]            regRdata,
  // Activity inputs, asynchronous
  input  wire wdt_pkg::pause_in_t pauseIn,
  // Device reset request and status
  output logic                   expiryPulse,
  output logic                   resetCauseWatchdog
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hitReload  = regReq.addr == RELOAD_VALUE_ADDR;
  wire hitControl = regReq.addr == CONTROL_ADDR;
  wire hitStrobe  = regReq.addr == RELOAD_STROBE_ADDR;
  wire hitCount   = regReq.addr == CURRENT_COUNT_ADDR;

  wire wrReload   = regReq.write && hitReload;
  wire wrControl  = regReq.write && hitControl;
  wire wrStrobe   = regReq.write && hitStrobe;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] reloadValue;
  logic        watchdogOn;
  logic        expiryFlag;
  logic        hibernationPauseAllow;
  logic        weekPauseAllow;
  logic        debugPauseAllow;
  logic [15:0] count;
  logic        expiryEvent;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reloadValue <= RELOAD_RESET;
    end else if (wrReload) begin
      reloadValue <= regReq.wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      watchdogOn            <= 1'b0;
      hibernationPauseAllow <= 1'b0;
      weekPauseAllow        <= 1'b0;
      debugPauseAllow       <= 1'b0;
    end else if (wrControl) begin
      watchdogOn            <= regReq.wdata[CTRL_ON_BIT];
      hibernationPauseAllow <= regReq.wdata[CTRL_HIB_BIT];
      weekPauseAllow        <= regReq.wdata[CTRL_WEEK_BIT];
      debugPauseAllow       <= regReq.wdata[CTRL_DEBUG_BIT];
    end
  end

  // Only power-on reset and a written one clear it, so it outlives the forced reset
  wire flagClear = wrControl && regReq.wdata[CTRL_FLAG_BIT];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      expiryFlag <= 1'b0;
    end else if (expiryEvent) begin
      expiryFlag <= 1'b1;
    end else if (flagClear) begin
      expiryFlag <= 1'b0;
    end
  end

  assign resetCauseWatchdog = expiryFlag;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] controlRead = {3'h0, debugPauseAllow, weekPauseAllow,
                            hibernationPauseAllow, expiryFlag, watchdogOn};

  // Kick register and unmapped words read zero
  wire [15:0] readMux = hitReload  ? reloadValue :
                        hitControl ? {8'h00, controlRead} :
                        hitCount   ? count : 16'h0000;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 16'h0000;
    end else if (regReq.read) begin
      regRdata <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // Slow-rate enable
  // ----------------------------------------------------------------
  localparam logic [9:0] SLOW_LAST = 10'(SLOW_CYCLES - 1);
  logic [9:0] slowCnt;
  wire        slowTick = slowCnt == SLOW_LAST;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slowCnt <= 10'h000;
    end else begin
      slowCnt <= slowTick ? 10'h000 : slowCnt + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Activity inputs: two-flop synchronisers
  // ----------------------------------------------------------------
  pause_in_t pauseMeta;
  pause_in_t pauseSync;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pauseMeta <= '0;
      pauseSync <= '0;
    end else begin
      pauseMeta <= pauseIn;
      pauseSync <= pauseMeta;
    end
  end

  wire stallNow = (pauseSync.hibernation_timer_running && hibernationPauseAllow) ||
                  (pauseSync.week_timer_running && weekPauseAllow) ||
                  (pauseSync.debug_port_running && debugPauseAllow);

  // ----------------------------------------------------------------
  // Requests held until the next slow tick, none lost
  // ----------------------------------------------------------------
  logic loadSettled;
  logic kickPending;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loadSettled <= 1'b1;
    end else if (wrReload) begin
      loadSettled <= 1'b0;
    end else if (slowTick) begin
      loadSettled <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      kickPending <= 1'b0;
    end else if (wrStrobe && watchdogOn) begin
      kickPending <= 1'b1;
    end else if (slowTick || !watchdogOn) begin
      kickPending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Enable only counts once a fresh reload value has settled
  wire running    = watchdogOn && loadSettled;
  logic runningQ;
  logic stallQ;
  wire  start     = running && !runningQ;
  wire  unstall   = running && stallQ && !stallNow;
  wire  reloadNow = start || unstall ||
                    (running && slowTick && kickPending) ||
                    (running && slowTick && !loadSettled);
  wire  counting  = running && !stallNow && !reloadNow;

  logic [14:0] stepCnt;
  localparam int unsigned STEP_LAST = STEP_CYCLES_P - 1;
  wire  stepTick  = counting && (stepCnt == 15'(STEP_LAST));
  assign expiryEvent = stepTick && (count == ZERO_COUNT);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      runningQ <= 1'b0;
      stallQ   <= 1'b0;
    end else begin
      runningQ <= running;
      stallQ   <= stallNow;
    end
  end

  // Step divider frozen when idle, so nothing toggles
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stepCnt <= 15'h0000;
    end else if (!counting || stepTick) begin
      stepCnt <= 15'h0000;
    end else begin
      stepCnt <= stepCnt + 15'h0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= RELOAD_RESET;
    end else if (!watchdogOn || reloadNow) begin
      count <= reloadValue;
    end else if (expiryEvent) begin
      count <= reloadValue;
    end else if (stepTick) begin
      count <= count - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Expiry output, one slow period wide
  // ----------------------------------------------------------------
  logic [9:0] pulseCnt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulseCnt <= 10'h000;
    end else if (!watchdogOn) begin
      pulseCnt <= 10'h000;
    end else if (expiryEvent) begin
      pulseCnt <= 10'(SLOW_CYCLES);
    end else if (pulseCnt != 10'h000) begin
      pulseCnt <= pulseCnt - 10'h001;
    end
  end

  // Goes only to the reset controller, never to an interrupt
  assign expiryPulse = watchdogOn && (pulseCnt != 10'h000);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int SLOW_WAIT = SLOW_CYCLES + 1;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence sKickTaken;
    wrStrobe && watchdogOn;
  endsequence

  sequence sKickServed;
    ##[0:SLOW_WAIT] ((kickPending && slowTick) || !watchdogOn);
  endsequence

  a_off_no_expiry: assert property (!watchdogOn |-> !expiryPulse)
    else $error("expiry output high while disabled");

  a_kick_ignored_off: assert property (wrStrobe && !watchdogOn |=> !kickPending)
    else $error("kick accepted while disabled");

  a_kick_served_in: assert property (sKickTaken |=> sKickServed)
    else $error("kick not served within one slow period");

  a_expiry_sets_flag: assert property (expiryEvent |=> expiryFlag && expiryPulse)
    else $error("expiry did not set flag and pulse");

  a_flag_zero_write: assert property (expiryFlag && wrControl &&
                                      !regReq.wdata[CTRL_FLAG_BIT] |=> expiryFlag)
    else $error("flag cleared by a zero write");

  a_zero_reloads: assert property (expiryEvent && watchdogOn |=>
                                   count == $past(reloadValue))
    else $error("counter not reloaded after zero");

  a_step_decrement: assert property (stepTick && count != ZERO_COUNT && watchdogOn |=>
                                     count == $past(count) - 16'h0001)
    else $error("counter did not step down by one");

  a_stall_holds_count: assert property (running && stallNow ##1 running && stallNow
                                        |-> $stable(count))
    else $error("counter moved while stalled");

  a_reload_holds_on: assert property (wrReload |=> !running)
    else $error("counting before reload value settled");

  a_pulse_width_min: assert property ($rose(expiryPulse) |->
                                      (expiryPulse || !watchdogOn)[*8])
    else $error("expiry pulse too short");

  // Length of the running expiry pulse, for the width check
  logic [9:0] pulseLen;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulseLen <= 10'h000;
    end else if (expiryPulse) begin
      pulseLen <= pulseLen + 10'h001;
    end else begin
      pulseLen <= 10'h000;
    end
  end

  // A disable cuts the pulse short, so only natural ends are judged
  a_pulse_width_full: assert property ($fell(expiryPulse) && watchdogOn |->
                                       pulseLen == 10'(SLOW_CYCLES))
    else $error("expiry pulse not one slow period wide");

  a_kick_reloads: assert property (running && slowTick && kickPending |=>
                                   count == $past(reloadValue))
    else $error("served kick did not reload the counter");

  a_unstall_reloads: assert property (unstall |=> count == $past(reloadValue))
    else $error("counter not reloaded when stall ended");

  a_disable_at_once: assert property (wrControl && !regReq.wdata[CTRL_ON_BIT] |=>
                                      !expiryPulse && !running)
    else $error("disable did not stop the watchdog at once");

  a_flag_write_one: assert property (flagClear && !expiryEvent |=> !expiryFlag)
    else $error("flag not cleared by a written one");

  a_kick_reads_zero: assert property (regReq.read && hitStrobe |=>
                                      regRdata == 16'h0000)
    else $error("kick register did not read zero");

endmodule

`default_nettype wire

// >>> testbench/ec_master.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Controller side of the register bus
// ----------------------------------------------------------------
module ec_master (
  // Clock
  input  wire logic              clock,
  // Register bus
  output var  wdt_pkg::reg_req_t regReq,
  input  wire logic [15:0]       regRdata
);
  import wdt_pkg::*;

  initial regReq = '0;

  // Caller enters just after an edge; one strobe, then a quiet cycle
  task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    reg_req_t r;
    r       = '0;
    r.write = w;
    r.read  = !w;
    r.addr  = a;
    r.wdata = d;
    regReq  = r;
    @(posedge clock);
    #1;
    // Released lines show a changed pattern, not the last value
    r.write = 1'b0;
    r.read  = 1'b0;
    r.addr  = ~a;
    r.wdata = ~d;
    regReq  = r;
    @(posedge clock);
    #1 q = regRdata;
  endtask
endmodule

`default_nettype wire

// >>> testbench/watchdog_timer_with_stall_bench.sv
`timescale 1ns/1ns
`default_nettype none

module watchdog_timer_with_stall_bench;
  import wdt_pkg::*;

  // Short step keeps the run small
  localparam int unsigned STEP = 20;

  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  reg_req_t    regReq;
  logic [15:0] regRdata;
  pause_in_t   pauseIn = '0;
  logic        expiryPulse;
  logic        resetCauseWatchdog;
  logic [15:0] q;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;

  always #25 clock = ~clock;

  watchdog_timer_with_stall #(.STEP_CYCLES_P(STEP)) dut (
    .clock(clock), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .pauseIn(pauseIn), .expiryPulse(expiryPulse),
    .resetCauseWatchdog(resetCauseWatchdog)
  );

  ec_master m (.clock(clock), .regReq(regReq), .regRdata(regRdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    m.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a);
    m.xfer(1'b0, a, 16'h0000, q);
  endtask

  // Cycles until expiry is seen high, -1 if not within lim
  task automatic wait_exp(input int lim);
    n = -1;
    for (int i = 0; i < lim && n < 0; i++) begin
      if (expiryPulse === 1'b1) n = i;
      else tick(1);
    end
  endtask

  // Reload must settle one slow period before enabling
  task automatic arm(input logic [15:0] v, input logic [7:0] ctl);
    wr(RELOAD_VALUE_ADDR, v);
    tick(SLOW_CYCLES + 2);
    wr(CONTROL_ADDR, {8'h00, ctl});
  endtask

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(RELOAD_VALUE_ADDR);
    check("reload", RELOAD_RESET, q);
    rd(CONTROL_ADDR);
    check("control", 16'h0000, q);
    rd(CURRENT_COUNT_ADDR);
    check("count", 16'hFFFF, q);
    rd(RELOAD_STROBE_ADDR);
    check("kick read", 16'h0000, q);
    wr(RELOAD_STROBE_ADDR, 16'h00A5);
    rd(CURRENT_COUNT_ADDR);
    check("kick while off", 16'hFFFF, q);
    rd(32'h4002_0410);
    check("unmapped", 16'h0000, q);
    $display("test reset done");
  endtask

  task automatic t_expire;
    int w;
    arm(16'h0028, 8'h01);
    rd(CURRENT_COUNT_ADDR);
    check("count at start", 16'h0028, q);
    rd(RELOAD_VALUE_ADDR);
    check("reload readback", 16'h0028, q);
    wait_exp(41 * STEP + 40);
    check("interval", 16'h0001, 16'(n >= 41 * STEP - 12 && n <= 41 * STEP + 6));
    check("flag out", 16'h0001, 16'(resetCauseWatchdog));
    w = 0;
    while (expiryPulse === 1'b1 && w < 1000) begin
      w++;
      tick(1);
    end
    check("pulse width", 16'(SLOW_CYCLES), 16'(w));
    rd(CONTROL_ADDR);
    check("control flag", 16'h0003, q);
    wr(CONTROL_ADDR, 16'h0001);
    check("flag zero write", 16'h0001, 16'(resetCauseWatchdog));
    wait_exp(41 * STEP + 40);
    check("second expiry", 16'h0001, 16'(n >= 0));
    wr(CONTROL_ADDR, 16'h0000);
    check("off drops pulse", 16'h0000, 16'(expiryPulse));
    wr(CONTROL_ADDR, 16'h0002);
    check("flag cleared", 16'h0000, 16'(resetCauseWatchdog));
    $display("test expire done");
  endtask

  task automatic t_kick;
    arm(16'h003C, 8'h01);
    for (int i = 0; i < 10; i++) begin
      wait_exp(300);
      check("kept alive", 16'hFFFF, 16'(n));
      wr(RELOAD_STROBE_ADDR, 16'h00A5);
    end
    wait_exp(61 * STEP + 700);
    check("starved expiry", 16'h0001, 16'(n >= 0));
    wr(CONTROL_ADDR, 16'h0002);
    $display("test kick done");
  endtask

  task automatic t_stall;
    for (int i = 0; i < 3; i++) begin
      pauseIn = pause_in_t'(3'b100 >> i);
      arm(16'h0003, 8'h01 | (8'h04 << i));
      rd(CONTROL_ADDR);
      check("stall enable", {8'h00, 8'h01 | (8'h04 << i)}, q);
      wait_exp(300);
      check("stalled", 16'hFFFF, 16'(n));
      rd(CURRENT_COUNT_ADDR);
      check("held count", 16'h0003, q);
      pauseIn = '0;
      wait_exp(4 * STEP + 40);
      check("resumed", 16'h0001, 16'(n >= 0));
      wr(CONTROL_ADDR, 16'h0002);
    end
    pauseIn = '1;
    arm(16'h0003, 8'h01);
    wait_exp(4 * STEP + 40);
    check("stall ignored", 16'h0001, 16'(n >= 0));
    wr(CONTROL_ADDR, 16'h0002);
    pauseIn = '0;
    $display("test stall done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    tick(3);
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_expire();
    t_kick();
    t_stall();
    print_verdict();
  end
endmodule

`default_nettype wire
